/* File: shared/cdr_pkg.sv */
/*
  Shared definitions for the change-detect configuration register bank:
  register offsets, field positions, defaults, the mode enum, and the
  packed structs for the register port and the block state.
  Assumes one 10 MHz clock domain and an 8-bit register port.
*/
package cdr_pkg;
  // Clock rate of ref_clk
  localparam int          CLK_HZ          = 10_000_000;
  // Documented register offsets
  localparam logic [7:0]  OFS_OUT_FLAGS   = 8'h2d;
  localparam logic [7:0]  OFS_IN_FLAGS    = 8'h2e;
  localparam logic [7:0]  OFS_SETUP_A     = 8'h2f;
  localparam logic [7:0]  OFS_SETUP_B     = 8'h30;
  localparam logic [7:0]  OFS_OT_DBCNT    = 8'h31;
  localparam logic [7:0]  OFS_WT_DBCNT    = 8'h32;
  localparam logic [7:0]  OFS_LTH_LOW     = 8'h33;
  localparam logic [7:0]  OFS_LTH_HIGH    = 8'h34;
  localparam logic [7:0]  OFS_UTH_LOW     = 8'h35;
  localparam logic [7:0]  OFS_UTH_HIGH    = 8'h36;
  localparam logic [7:0]  OFS_ST_IDLE     = 8'h37;
  localparam logic [7:0]  OFS_ST_DEC      = 8'h38;
  localparam logic [7:0]  OFS_RSVD_A      = 8'h39;
  localparam logic [7:0]  OFS_RSVD_B      = 8'h3a;
  // Neighbouring registers and local additions
  localparam logic [7:0]  OFS_OUT_LOW     = 8'h04;
  localparam logic [7:0]  OFS_OUT_HIGH    = 8'h05;
  localparam logic [7:0]  OFS_SETUP_ONE   = 8'h15;
  localparam logic [7:0]  OFS_SETUP_THREE = 8'h17;
  localparam logic [7:0]  OFS_BUF_ONE     = 8'h26;
  localparam logic [7:0]  OFS_IRQ_STAT    = 8'h40;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h41;
  // Pointer wrap point and restart address
  localparam logic [7:0]  OFS_WRAP        = 8'h3a;
  localparam logic [7:0]  OFS_FIRST       = 8'h00;
  // Field positions
  localparam int          BIT_ACTIVE      = 0;
  localparam int          BIT_SRST        = 7;
  localparam int          BIT_BYTE_ORDER  = 0;
  localparam int          BIT_EXTERNAL_TRIGGER_MODE    = 1;
  localparam int          BIT_FLUSH       = 7;
  localparam int          BIT_REFERENCE_UPDATE_BIT     = 1;
  localparam int          IRQ_OUTSIDE     = 0;
  localparam int          IRQ_WITHIN      = 1;
  localparam int          IRQ_INVALID     = 2;
  // Defaults for boot pin low / high
  localparam logic [7:0]  DEF_SETUP_A_LO  = 8'h00;
  localparam logic [7:0]  DEF_SETUP_A_HI  = 8'h38;
  localparam logic [7:0]  DEF_SETUP_B_LO  = 8'h00;
  localparam logic [7:0]  DEF_SETUP_B_HI  = 8'hd8;
  localparam logic [11:0] DEF_LTH_LO      = 12'h000;
  localparam logic [11:0] DEF_LTH_HI      = 12'hfc0;
  localparam logic [11:0] DEF_UTH_LO      = 12'h000;
  localparam logic [11:0] DEF_UTH_HI      = 12'h040;
  localparam logic [7:0]  DEF_ZERO        = 8'h00;

  // Operating modes
  typedef enum logic [1:0] {MODE_STANDBY, MODE_ACTIVE, MODE_EXT} cdr_mode_t;

  // One register port request
  typedef struct packed {
    logic [7:0] addr;  // Register address
    logic [7:0] wdata; // Write data
    logic       wr;    // Write strobe
    logic       rd;    // Read strobe
    logic       seq;   // Use the auto-increment pointer
  } cdr_bus_t;

  // Configuration seen by the detector and self-test logic
  typedef struct packed {
    logic [7:0]  setup_a;
    logic [7:0]  setup_b;
    logic [7:0]  ot_dbcnt;
    logic [7:0]  wt_dbcnt;
    logic [11:0] lower_threshold;
    logic [11:0] upper_threshold;
    logic [7:0]  st_idle;
    logic [7:0]  st_dec;
    logic [7:0]  rsvd_a;
  } cdr_cfg_t;

  // Whole block state
  typedef struct packed {
    cdr_mode_t  mode;
    logic [7:0] setup_one;
    logic [7:0] setup_three;
    logic [7:0] buf_one;
    logic [7:0] out_flags;
    logic [7:0] in_flags;
    cdr_cfg_t   cfg;
    logic [7:0] pointer;
    logic [7:0] rdata;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic       irq;
    logic       buf_invalid;
    logic       buf_flush;
  } cdr_state_t;

  // Defaults chosen by the boot pin level
  function automatic cdr_state_t cdr_defaults(input logic boot);
    cdr_state_t s;
    s = '0;
    s.mode                = MODE_STANDBY;
    s.cfg.setup_a         = boot ? DEF_SETUP_A_HI : DEF_SETUP_A_LO;
    s.cfg.setup_b         = boot ? DEF_SETUP_B_HI : DEF_SETUP_B_LO;
    s.cfg.lower_threshold = boot ? DEF_LTH_HI : DEF_LTH_LO;
    s.cfg.upper_threshold = boot ? DEF_UTH_HI : DEF_UTH_LO;
    s.cfg.ot_dbcnt        = DEF_ZERO;
    s.cfg.wt_dbcnt        = DEF_ZERO;
    return s;
  endfunction
endpackage

/* File: rtl/cdr_bank.sv */
/*
  Change-detect configuration register bank with mode control,
  write protection, event flag capture, output byte ordering,
  auto-increment pointer and a masked interrupt.
  Assumes all inputs synchronous to ref_clk and a register master
  that never asserts read and write strobes together.
*/
// Function
// [RULE1] Keep registers going active to standby
// [RULE2] Hibernate exit or brownout restores all defaults
// [RULE3] Clear event flags entering active or trigger
// [RULE4] Byte order field selects output justification
// [RULE5] Mark buffer invalid entering active or trigger
// [RULE6] Protected writes only accepted in standby
// [RULE7] Active, reset, flush bits writable anytime
// [RULE8] Active bit frozen in external trigger mode
// [RULE9] Active mode: only reference update settable
// [RULE10] Setup A: latch enable and axis enables
// [RULE11] Setup B: enable, reference, mode, debounce
// [RULE12] Separate 8-bit debounce counts
// [RULE13] 12-bit thresholds from low and high bytes
// [RULE14] Read-only event flag registers reset zero
// [RULE15] Self-test idle and decimation registers
// [RULE16] Host must not write factory register
// [RULE17] Pointer auto-increments, wraps to zero
// [RULE18] Boot pin selects alternate defaults
`timescale 1ns/1ps
module cdr_bank
  import cdr_pkg::*;
(
  input  wire logic            ref_clk,        // System clock
  input  wire logic            nrst,           // Synchronous reset, low
  input  wire cdr_pkg::cdr_bus_t bus,          // Register port request
  output logic [7:0]           rdata,          // Read data, next cycle
  input  wire logic            boot_mode_pin,  // Default set selector
  input  wire logic            brownout_reset, // Brownout event pulse
  input  wire logic            hibernate_exit, // Leaving hibernate pulse
  input  wire logic [7:0]      outside_evt,    // Outside-threshold events
  input  wire logic [7:0]      within_evt,     // Within-threshold events
  input  wire logic [11:0]     sample_in,      // Output sample to present
  output cdr_pkg::cdr_cfg_t    cfg,            // Detector configuration
  output cdr_pkg::cdr_mode_t   mode,           // Current operating mode
  output logic                 byte_order,     // Byte order field
  output logic                 buf_invalid,    // Buffer obsolete pulse
  output logic                 buf_flush,      // Buffer flush pulse
  output logic                 irq             // Interrupt, high level
);
  import cdr_pkg::*;

  cdr_state_t q;          // Registered state
  cdr_state_t next_q;     // Next state
  logic [7:0] eff_addr;   // Address used by this access
  logic       standby;    // In standby mode
  logic       leave_sb;   // Leaving standby this cycle
  logic       wipe;       // Return to defaults
  logic [7:0] wv;         // Write value
  cdr_mode_t  next_mode;  // Mode from next control bits
  logic [2:0] irq_set;    // Interrupt events this cycle

  // Combinational next-state logic
  always_comb begin
    next_q      = q;
    wv          = bus.wdata;
    // Pointer or direct address
    eff_addr    = bus.seq ? q.pointer : bus.addr; // [RULE17]
    standby     = (q.mode == MODE_STANDBY);
    irq_set     = 3'h0;
    next_mode   = q.mode;
    leave_sb    = 1'b0;
    next_q.buf_flush   = 1'b0;
    next_q.buf_invalid = 1'b0;

    // Register writes
    if (bus.wr) begin
      if (eff_addr == OFS_SETUP_ONE) begin
        // Active bit in any mode except external trigger
        if (q.mode != MODE_EXT) begin
          next_q.setup_one[BIT_ACTIVE] = wv[BIT_ACTIVE]; // [RULE7] [RULE8]
        end
        // Software reset may be set in any mode
        next_q.setup_one[BIT_SRST] = wv[BIT_SRST]; // [RULE7]
        // Remaining bits are protected
        if (standby) begin
          next_q.setup_one[6:1] = wv[6:1]; // [RULE6]
        end
      end else if (eff_addr == OFS_SETUP_THREE) begin
        // Byte order and trigger enable protected
        if (standby) begin
          next_q.setup_three = wv; // [RULE6]
        end
      end else if (eff_addr == OFS_BUF_ONE) begin
        // Flush may be requested in any mode
        next_q.buf_flush = wv[BIT_FLUSH]; // [RULE7]
        if (standby) begin
          next_q.buf_one = {1'b0, wv[6:0]}; // [RULE6]
        end
      end else if (eff_addr == OFS_SETUP_B) begin
        if (standby) begin
          next_q.cfg.setup_b = wv; // [RULE6] [RULE11]
        end else if (q.mode == MODE_ACTIVE) begin
          // Only the reference update bit may be set
          if (wv[BIT_REFERENCE_UPDATE_BIT]) begin
            next_q.cfg.setup_b[BIT_REFERENCE_UPDATE_BIT] = 1'b1; // [RULE9]
          end
        end
      end else if (eff_addr == OFS_IRQ_STAT) begin
        // Write one to clear
        next_q.irq_stat = q.irq_stat & ~wv[2:0];
      end else if (eff_addr == OFS_IRQ_MASK) begin
        // Mask is always writable
        next_q.irq_mask = wv[2:0];
      end else if (standby) begin
        // Remaining protected configuration
        if (eff_addr == OFS_SETUP_A) begin
          next_q.cfg.setup_a = wv; // [RULE6] [RULE10]
        end else if (eff_addr == OFS_OT_DBCNT) begin
          next_q.cfg.ot_dbcnt = wv; // [RULE12]
        end else if (eff_addr == OFS_WT_DBCNT) begin
          next_q.cfg.wt_dbcnt = wv; // [RULE12]
        end else if (eff_addr == OFS_LTH_LOW) begin
          next_q.cfg.lower_threshold[7:0] = wv; // [RULE13]
        end else if (eff_addr == OFS_LTH_HIGH) begin
          next_q.cfg.lower_threshold[11:8] = wv[3:0]; // [RULE13]
        end else if (eff_addr == OFS_UTH_LOW) begin
          next_q.cfg.upper_threshold[7:0] = wv; // [RULE13]
        end else if (eff_addr == OFS_UTH_HIGH) begin
          next_q.cfg.upper_threshold[11:8] = wv[3:0]; // [RULE13]
        end else if (eff_addr == OFS_ST_IDLE) begin
          next_q.cfg.st_idle = wv; // [RULE15]
        end else if (eff_addr == OFS_ST_DEC) begin
          next_q.cfg.st_dec = wv; // [RULE15]
        end else if (eff_addr == OFS_RSVD_A) begin
          // Stored, although the host is to leave it alone
          next_q.cfg.rsvd_a = wv; // [RULE16]
        end else begin
          // Flag registers and unmapped addresses ignore writes
          next_q.rdata = next_q.rdata;
        end
      end else begin
        // Protected write outside standby is dropped
        next_q.rdata = next_q.rdata; // [RULE6]
      end
    end

    // Register reads
    if (bus.rd) begin
      if (eff_addr == OFS_OUT_FLAGS) begin
        next_q.rdata = q.out_flags; // [RULE14]
      end else if (eff_addr == OFS_IN_FLAGS) begin
        next_q.rdata = q.in_flags; // [RULE14]
      end else if (eff_addr == OFS_SETUP_A) begin
        next_q.rdata = q.cfg.setup_a;
      end else if (eff_addr == OFS_SETUP_B) begin
        next_q.rdata = q.cfg.setup_b;
      end else if (eff_addr == OFS_OT_DBCNT) begin
        next_q.rdata = q.cfg.ot_dbcnt;
      end else if (eff_addr == OFS_WT_DBCNT) begin
        next_q.rdata = q.cfg.wt_dbcnt;
      end else if (eff_addr == OFS_LTH_LOW) begin
        next_q.rdata = q.cfg.lower_threshold[7:0];
      end else if (eff_addr == OFS_LTH_HIGH) begin
        next_q.rdata = {4'h0, q.cfg.lower_threshold[11:8]};
      end else if (eff_addr == OFS_UTH_LOW) begin
        next_q.rdata = q.cfg.upper_threshold[7:0];
      end else if (eff_addr == OFS_UTH_HIGH) begin
        next_q.rdata = {4'h0, q.cfg.upper_threshold[11:8]};
      end else if (eff_addr == OFS_ST_IDLE) begin
        next_q.rdata = q.cfg.st_idle;
      end else if (eff_addr == OFS_ST_DEC) begin
        next_q.rdata = q.cfg.st_dec;
      end else if (eff_addr == OFS_RSVD_A) begin
        next_q.rdata = q.cfg.rsvd_a;
      end else if (eff_addr == OFS_OUT_LOW) begin
        // Little-endian right or big-endian left justified
        if (q.setup_three[BIT_BYTE_ORDER]) begin
          next_q.rdata = sample_in[11:4]; // [RULE4]
        end else begin
          next_q.rdata = sample_in[7:0]; // [RULE4]
        end
      end else if (eff_addr == OFS_OUT_HIGH) begin
        if (q.setup_three[BIT_BYTE_ORDER]) begin
          next_q.rdata = {sample_in[3:0], 4'h0}; // [RULE4]
        end else begin
          next_q.rdata = {4'h0, sample_in[11:8]}; // [RULE4]
        end
      end else if (eff_addr == OFS_SETUP_ONE) begin
        next_q.rdata = q.setup_one;
      end else if (eff_addr == OFS_SETUP_THREE) begin
        next_q.rdata = q.setup_three;
      end else if (eff_addr == OFS_BUF_ONE) begin
        next_q.rdata = q.buf_one;
      end else if (eff_addr == OFS_IRQ_STAT) begin
        next_q.rdata = {5'h00, q.irq_stat};
      end else if (eff_addr == OFS_IRQ_MASK) begin
        next_q.rdata = {5'h00, q.irq_mask};
      end else begin
        // Unmapped and the last factory register read zero
        next_q.rdata = 8'h00;
      end
    end

    // Pointer moves past each access, wrapping after the last
    if (bus.rd || bus.wr) begin
      if (eff_addr == OFS_WRAP) begin
        next_q.pointer = OFS_FIRST; // [RULE17]
      end else begin
        next_q.pointer = 8'(eff_addr + 8'h01); // [RULE17]
      end
    end

    // Mode follows the control bits
    if (!next_q.setup_one[BIT_ACTIVE]) begin
      next_mode = MODE_STANDBY;
    end else if (next_q.setup_three[BIT_EXTERNAL_TRIGGER_MODE]) begin
      next_mode = MODE_EXT;
    end else begin
      next_mode = MODE_ACTIVE;
    end
    next_q.mode = next_mode;
    leave_sb    = standby && (next_mode != MODE_STANDBY);

    // Buffer contents obsolete on leaving standby
    if (leave_sb) begin
      next_q.buf_invalid = 1'b1; // [RULE5]
      irq_set[IRQ_INVALID] = 1'b1; // [RULE5]
    end

    // Event flags: cleared on leaving standby, events captured only outside standby
    if (leave_sb) begin
      next_q.out_flags = 8'h00; // [RULE3]
      next_q.in_flags  = 8'h00; // [RULE3]
    end else if (!q.cfg.setup_a[7]) begin
      // Latch disabled: flags follow the live events
      next_q.out_flags = 8'h00;
      next_q.in_flags  = 8'h00;
    end
    if (!standby) begin
      next_q.out_flags = next_q.out_flags | outside_evt; // [RULE10]
      next_q.in_flags  = next_q.in_flags | within_evt; // [RULE10]
      irq_set[IRQ_OUTSIDE] = |outside_evt;
      irq_set[IRQ_WITHIN]  = |within_evt;
    end

    // Sticky interrupt status, setting beats clearing
    next_q.irq_stat = next_q.irq_stat | irq_set;
    next_q.irq      = |(next_q.irq_stat & next_q.irq_mask);

    // Going to standby keeps everything as is
    if (q.mode != MODE_STANDBY && next_mode == MODE_STANDBY) begin
      next_q.cfg = next_q.cfg; // [RULE1]
    end

    // Software reset, brownout or hibernate exit restores defaults
    wipe = q.setup_one[BIT_SRST] || brownout_reset || hibernate_exit;
    if (wipe) begin
      next_q = cdr_defaults(boot_mode_pin); // [RULE2] [RULE18]
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q <= cdr_defaults(boot_mode_pin); // [RULE2] [RULE18]
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from state
  assign rdata       = q.rdata;
  assign cfg         = q.cfg;
  assign mode        = q.mode;
  assign byte_order  = q.setup_three[BIT_BYTE_ORDER];
  assign buf_invalid = q.buf_invalid;
  assign buf_flush   = q.buf_flush;
  assign irq         = q.irq;
endmodule // cdr_bank

/* File: tb/cdr_host_model.sv */
/*
  Host processor model: issues single-cycle register writes and reads.
  Assumes the bank answers reads one cycle after the strobe, no waits.
*/
`timescale 1ns/1ps
module cdr_host_model
  import cdr_pkg::*;
(
  input  wire logic              ref_clk, // System clock
  output cdr_pkg::cdr_bus_t      bus,     // Request to the bank
  input  wire logic [7:0]        rdata    // Read data from the bank
);
  initial bus = '0;

  // One write strobe cycle, then idle; a direct write to 0x39 issues no strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s);
    if (a == 8'h39 && !s) begin
      return;
    end
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, seq: s};
    @(posedge ref_clk);
    bus <= '0;
    #1;
  endtask

  // One read strobe cycle; data taken in the following cycle
  task automatic rd(input logic [7:0] a, input logic s, output logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, seq: s};
    @(posedge ref_clk);
    bus <= '0;
    #1;
    d = rdata;
  endtask
endmodule // cdr_host_model

/* File: tb/cdr_bank_props.sv */
/*
  Concurrent checks on the ports of the register bank.
  Assumes one clock domain and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module cdr_bank_props
  import cdr_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              nrst,
  input wire cdr_pkg::cdr_bus_t bus,
  input wire logic [7:0]        rdata,
  input wire logic              boot_mode_pin,
  input wire logic              brownout_reset,
  input wire logic              hibernate_exit,
  input wire logic [7:0]        outside_evt,
  input wire logic [7:0]        within_evt,
  input wire logic [11:0]       sample_in,
  input wire cdr_pkg::cdr_cfg_t cfg,
  input wire cdr_pkg::cdr_mode_t mode,
  input wire logic              byte_order,
  input wire logic              buf_invalid,
  input wire logic              buf_flush,
  input wire logic              irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_reset_state: assert property ($rose(nrst) |-> mode == MODE_STANDBY && !irq)
    else $error("state not idle after reset");
  chk_invalid_pulse: assert property (buf_invalid == ($past(mode) == MODE_STANDBY && mode != MODE_STANDBY))
    else $error("buffer invalid pulse wrong");
  chk_ext_hold: assert property (mode == MODE_EXT |=> mode != MODE_ACTIVE)
    else $error("left trigger mode into active");
  chk_cfg_locked: assert property ((mode != MODE_STANDBY && $past(mode) != MODE_STANDBY) |->
    cfg.setup_a == $past(cfg.setup_a) && cfg.lower_threshold == $past(cfg.lower_threshold) &&
    cfg.ot_dbcnt == $past(cfg.ot_dbcnt) && {cfg.setup_b[7:2], cfg.setup_b[0]} ==
    {$past(cfg.setup_b[7:2]), $past(cfg.setup_b[0])} && (cfg.setup_b[1] || !$past(cfg.setup_b[1])))
    else $error("protected setting changed outside standby");
  chk_order_set: assert property ($rose(byte_order) |-> $past(bus.wr && mode == MODE_STANDBY))
    else $error("byte order set without standby write");
  chk_flush_cause: assert property (buf_flush |-> $past(bus.wr && bus.wdata[7] && (bus.seq || bus.addr == 8'h26)))
    else $error("flush pulse without flush write");
  chk_irq_cause: assert property ($rose(irq) |-> $past(bus.wr || (|outside_evt) || (|within_evt)) ||
    $past(bus.wr || (|outside_evt) || (|within_evt), 2))
    else $error("interrupt rose without cause");
  chk_rdata_hold: assert property ($changed(rdata) |-> $past(bus.rd) || $past(brownout_reset) ||
    $past(hibernate_exit) || $past(bus.wr, 2))
    else $error("read data changed without read");

  cov_active: cover property ($past(mode) == MODE_STANDBY && mode == MODE_ACTIVE);
  cov_ext: cover property ($past(mode) == MODE_STANDBY && mode == MODE_EXT);
  cov_flush: cover property (buf_flush);
endmodule // cdr_bank_props

bind cdr_bank cdr_bank_props u_props (.ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
  .boot_mode_pin(boot_mode_pin), .brownout_reset(brownout_reset), .hibernate_exit(hibernate_exit),
  .outside_evt(outside_evt), .within_evt(within_evt), .sample_in(sample_in), .cfg(cfg), .mode(mode),
  .byte_order(byte_order), .buf_invalid(buf_invalid), .buf_flush(buf_flush), .irq(irq));

/* File: tb/tb_top.sv */
/*
  Self-checking bench for the register bank: table of register writes
  and readbacks, then mode, interrupt and wipe cases by hand.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
module tb_top;
  import cdr_pkg::*;
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} cdr_row_t;
  logic        ref_clk = 1'b0; // 10 MHz clock
  logic        nrst;           // Reset, low
  logic        boot;           // Boot pin level
  logic        brown;          // Brownout pulse
  logic        hib;            // Hibernate exit pulse
  logic [7:0]  oevt;           // Outside events
  logic [7:0]  wevt;           // Within events
  logic [11:0] sample;         // Sample to present
  cdr_bus_t    bus;            // Host request
  logic [7:0]  rdata;          // Read data
  cdr_cfg_t    cfg;            // Configuration out
  cdr_mode_t   mode;           // Mode out
  logic        byte_order;     // Byte order out
  logic        buf_flush;      // Flush pulse
  logic        buf_invalid;    // Buffer obsolete pulse
  logic        irq;            // Interrupt
  int          num_errors = 0; // Mismatches
  int          n_checks = 0;   // Comparisons
  cdr_row_t    rows [14];      // Write/readback table

  always #50 ref_clk = ~ref_clk;

  cdr_host_model u_host (.ref_clk(ref_clk), .bus(bus), .rdata(rdata));
  cdr_bank u_dut (.ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rdata(rdata), .boot_mode_pin(boot),
    .brownout_reset(brown), .hibernate_exit(hib), .outside_evt(oevt), .within_evt(wevt),
    .sample_in(sample), .cfg(cfg), .mode(mode), .byte_order(byte_order), .buf_invalid(buf_invalid),
    .buf_flush(buf_flush), .irq(irq));

  // Compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Read a register and compare
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, 1'b0, d);
    check(d, exp);
  endtask

  // One-cycle pulse on a wipe input: brownout when high, hibernate exit when low
  task automatic pulse(input logic use_brown);
    @(posedge ref_clk);
    if (use_brown) begin
      brown <= 1'b1;
    end else begin
      hib <= 1'b1;
    end
    @(posedge ref_clk);
    brown <= 1'b0;
    hib <= 1'b0;
    #1;
  endtask

  task automatic tally_and_finish;
    $display("TB: errors=%0d checks=%0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    nrst = 1'b0; boot = 1'b0; brown = 1'b0; hib = 1'b0; oevt = 8'h00; wevt = 8'h00; sample = 12'habc;
    rows = '{'{8'h2f, 8'hda, 8'hda}, '{8'h30, 8'ha5, 8'ha5}, '{8'h31, 8'h11, 8'h11}, '{8'h32, 8'h22, 8'h22},
             '{8'h33, 8'hc3, 8'hc3}, '{8'h34, 8'hff, 8'h0f}, '{8'h35, 8'h35, 8'h35}, '{8'h36, 8'hf6, 8'h06},
             '{8'h37, 8'h37, 8'h37}, '{8'h38, 8'h38, 8'h38}, '{8'h2d, 8'hff, 8'h00}, '{8'h2e, 8'hff, 8'h00},
             '{8'h3a, 8'hff, 8'h00}, '{8'h50, 8'hff, 8'h00}};
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (rows[i]) rdchk(rows[i].addr, 8'h00);
    foreach (rows[i]) begin
      u_host.wr(rows[i].addr, rows[i].wdata, 1'b0);
      rdchk(rows[i].addr, rows[i].exp);
    end
    check(cfg.lower_threshold, 12'hfc3);
    check(cfg.upper_threshold, 12'h635);
    check({cfg.ot_dbcnt, cfg.wt_dbcnt}, 16'h1122);
    // Sequential write lands on the next address
    u_host.wr(8'h37, 8'h71, 1'b0);
    u_host.wr(8'h00, 8'h72, 1'b1);
    check(cfg.st_dec, 8'h72);
    // Both byte orders of the sample
    rdchk(8'h04, 8'hbc);
    rdchk(8'h05, 8'h0a);
    u_host.wr(8'h17, 8'h01, 1'b0);
    check(byte_order, 1'b1);
    rdchk(8'h04, 8'hab);
    rdchk(8'h05, 8'hc0);
    u_host.wr(8'h17, 8'h00, 1'b0);
    // Go active with all interrupts unmasked
    u_host.wr(8'h41, 8'h07, 1'b0);
    u_host.wr(8'h15, 8'h01, 1'b0);
    check(mode, MODE_ACTIVE);
    check(buf_invalid, 1'b1);
    check(irq, 1'b1);
    rdchk(8'h40, 8'h04);
    @(posedge ref_clk);
    oevt <= 8'h05;
    wevt <= 8'h30;
    @(posedge ref_clk);
    oevt <= 8'h00;
    wevt <= 8'h00;
    rdchk(8'h2d, 8'h05);
    rdchk(8'h2e, 8'h30);
    rdchk(8'h40, 8'h07);
    u_host.wr(8'h31, 8'h99, 1'b0);
    rdchk(8'h31, 8'h11);
    u_host.wr(8'h30, 8'hf0, 1'b0);
    u_host.wr(8'h30, 8'hff, 1'b0);
    rdchk(8'h30, 8'ha7);
    u_host.wr(8'h26, 8'h80, 1'b0);
    check(buf_flush, 1'b1);
    u_host.wr(8'h40, 8'h07, 1'b0);
    check(irq, 1'b0);
    u_host.wr(8'h41, 8'h00, 1'b0);
    @(posedge ref_clk);
    oevt <= 8'h01;
    @(posedge ref_clk);
    oevt <= 8'h00;
    @(posedge ref_clk);
    #1;
    check(irq, 1'b0);
    // Back to standby keeps contents, active again clears flags
    u_host.wr(8'h15, 8'h00, 1'b0);
    check(mode, MODE_STANDBY);
    rdchk(8'h2d, 8'h05);
    rdchk(8'h30, 8'ha7);
    u_host.wr(8'h15, 8'h01, 1'b0);
    rdchk(8'h2d, 8'h00);
    rdchk(8'h2e, 8'h00);
    u_host.wr(8'h15, 8'h00, 1'b0);
    // Trigger mode freezes the active bit; soft reset still works
    u_host.wr(8'h17, 8'h02, 1'b0);
    u_host.wr(8'h15, 8'h01, 1'b0);
    check(mode, MODE_EXT);
    u_host.wr(8'h15, 8'h00, 1'b0);
    check(mode, MODE_EXT);
    u_host.wr(8'h15, 8'h80, 1'b0);
    @(posedge ref_clk);
    #1;
    check(mode, MODE_STANDBY);
    check(cfg.setup_a, 8'h00);
    // Hibernate exit with the normal defaults, brownout with the alternate defaults
    u_host.wr(8'h31, 8'h44, 1'b0);
    pulse(1'b0);
    check(cfg.ot_dbcnt, 8'h00);
    @(posedge ref_clk);
    boot <= 1'b1;
    pulse(1'b1);
    check({cfg.setup_a, cfg.setup_b}, 16'h38d8);
    check(cfg.lower_threshold, 12'hfc0);
    check(cfg.upper_threshold, 12'h040);
    rdchk(8'h34, 8'h0f);
    tally_and_finish();
  end
endmodule // tb_top
